/* File: ssmi_chk.sv */
// assertion checker for the serial port block
`timescale 1ns/10ps
module ssmi_chk (
  // clock and control
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       i2c_mode,
  input wire logic       buf_wr,
  input wire logic       buf_rd,
  input wire logic       pif_clr,
  input wire logic       ckp_wr,
  input wire logic       ckp_wdata,
  input wire logic       acknowledge_data_bit,
  input wire logic [2:0] rate_sel,
  // status and pins
  input wire logic       spi_busy,
  input wire logic       sck_out,
  input wire logic       clock_release_polarity_bit,
  input wire logic       port_interrupt_flag,
  input wire logic       buffer_full_flag,
  input wire logic       acknowledge_time_status,
  input wire logic       scl_oe,
  input wire logic       sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire go = ce && !i2c_mode && buf_wr && !spi_busy;
  property p_go; go |=> spi_busy; endproperty
  a_go: assert property (p_go) else $error("byte not started");
  property p_len; go && rate_sel == 3'h0 |=> spi_busy[*8] ##1 spi_busy[*8]
    ##1 spi_busy[*8] ##[1:12] !spi_busy; endproperty
  a_len: assert property (p_len) else $error("byte length wrong");
  property p_done; $fell(spi_busy) |-> ##[0:1] port_interrupt_flag && buffer_full_flag;
  endproperty
  a_done: assert property (p_done) else $error("rx flags not set");
  property p_idle; !i2c_mode && !spi_busy && !$past(spi_busy) && !$past(spi_busy, 2)
    && $stable(clock_release_polarity_bit) && $past(clock_release_polarity_bit, 2)
    == clock_release_polarity_bit |-> sck_out == clock_release_polarity_bit; endproperty
  a_idle: assert property (p_idle) else $error("sck idle level wrong");
  property p_bf; buf_rd && !i2c_mode && !spi_busy && !$past(spi_busy) |=> !buffer_full_flag;
  endproperty
  a_bf: assert property (p_bf) else $error("full flag not cleared");
  property p_pif; port_interrupt_flag && !pif_clr |=> port_interrupt_flag; endproperty
  a_pif: assert property (p_pif) else $error("flag dropped");
  property p_hold; i2c_mode && $fell(clock_release_polarity_bit) |-> ##[0:1] scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("scl not held");
  property p_rel; i2c_mode && ckp_wr && ckp_wdata && scl_oe |-> ##[1:2] !scl_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("scl not released");
  // the ack value is registered, so sda follows the software bit one cycle late
  property p_ack; i2c_mode && acknowledge_time_status && scl_oe
    |-> sda_oe == !$past(acknowledge_data_bit); endproperty
  a_ack: assert property (p_ack) else $error("ack value wrong");
endmodule : ssmi_chk
bind ssmi_port ssmi_chk u_chk (.*);

/* File: ssmi_pkg.sv */
// shared constants and types for the serial port block
package ssmi_pkg;

  // spi bit-rate selections
  typedef enum logic [2:0] {
    SSMI_RATE_DIV4   = 3'h0,
    SSMI_RATE_DIV16  = 3'h1,
    SSMI_RATE_DIV64  = 3'h2,
    SSMI_RATE_TMR2   = 3'h3,
    SSMI_RATE_RELOAD = 3'h4
  } ssmi_rate_t;

  // i2c slave receiver states
  typedef enum logic [1:0] {
    SSMI_I2C_IDLE = 2'h0,
    SSMI_I2C_RECV = 2'h1,
    SSMI_I2C_ACK  = 2'h2
  } ssmi_i2c_state_t;

  // half-bit lengths in system clocks for the fixed spi rates
  localparam logic [8:0] SSMI_HALF_DIV4  = 9'h002;
  localparam logic [8:0] SSMI_HALF_DIV16 = 9'h008;
  localparam logic [8:0] SSMI_HALF_DIV64 = 9'h020;
  // half-bits in one spi byte, minus one
  localparam logic [3:0] SSMI_LAST_PHASE = 4'hf;
  // scl rises taken before the fall that closes a byte
  localparam logic [3:0] SSMI_BITS_BYTE  = 4'h8;
  localparam logic [7:0] SSMI_BUF_RESET  = 8'h00;
  localparam logic       SSMI_CKP_RESET  = 1'b0;

endpackage : ssmi_pkg

/* File: ssmi_port.sv */
// synchronous serial port: spi master and i2c slave with address/data holding
//
// Summary of operation
// - spi master starts one full-duplex byte as soon as the buffer is written
// - spi received bytes load the buffer and set full and interrupt flags
// - polarity bit sets idle clock level; edge bit picks the launching edge
// - spi bytes leave most significant bit first
// - spi rate is clk/4, /16, /64, timer tick/2 or clk/(4*(reload+1))
// - with edge bit set, output data is valid before the first clock edge
// - with edge bit set, sample-phase bit picks where in the bit the input is sampled
// - hold options add interrupts and clock stretch after eighth scl fall
// - start sets start status; interrupt only when start interrupt is enabled
// - matching write address: flag set, release bit cleared, scl held low
// - ack-time status tells whether the interrupt was before the acknowledge
// - reading the buffer clears the buffer-full flag
// - software sets acknowledge value while held; slave drives it on sda
// - setting the release bit stops the slave holding scl low
// - interrupt after ninth scl fall when ack was sent, never after nack
// - with stretch enabled the slave also holds scl after the acknowledge
// - each data byte: flag set, release bit cleared at the eighth fall
// - stop sets stop status; interrupt only when stop interrupt is enabled
`timescale 1ns/10ps
module ssmi_port
  import ssmi_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // mode: 0 spi master, 1 i2c slave
  input  wire logic       i2c_mode,
  // buffer access
  input  wire logic       buf_wr,
  input  wire logic [7:0] buf_wdata,
  input  wire logic       buf_rd,
  output logic      [7:0] serial_data_buffer,
  // release/polarity bit
  input  wire logic       ckp_wr,
  input  wire logic       ckp_wdata,
  output logic            clock_release_polarity_bit,
  // flags
  input  wire logic       pif_clr,
  output logic            port_interrupt_flag,
  output logic            buffer_full_flag,
  output logic            start_seen,
  output logic            stop_seen,
  output logic            acknowledge_time_status,
  output logic            spi_busy,
  // spi configuration
  input  wire logic       clock_edge_select,
  input  wire logic       sample_phase_bit,
  input  wire logic [2:0] rate_sel,
  input  wire logic [7:0] baud_reload_value,
  input  wire logic       tmr2_tick,
  // i2c configuration
  input  wire logic [6:0] own_address,
  input  wire logic       address_hold_enable,
  input  wire logic       data_hold_enable,
  input  wire logic       clock_stretch_enable,
  input  wire logic       acknowledge_data_bit,
  input  wire logic       start_int_enable,
  input  wire logic       stop_int_enable,
  // spi pins
  output logic            sck_out,
  output logic            serial_data_output,
  input  wire logic       serial_data_input,
  // i2c open-drain pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  function automatic logic [8:0] half_limit(input logic [2:0] sel, input logic [7:0] rld);
    logic [8:0] lim;
    lim = SSMI_HALF_DIV4;
    case (sel)
      SSMI_RATE_DIV16:  lim = SSMI_HALF_DIV16;
      SSMI_RATE_DIV64:  lim = SSMI_HALF_DIV64;
      SSMI_RATE_RELOAD: lim = {rld, 1'b0} + 9'h002;
      default:          lim = SSMI_HALF_DIV4;
    endcase
    return lim;
  endfunction : half_limit

  // ---------------- spi master ----------------
  logic [8:0] div_cnt;
  logic [3:0] phase;
  logic [7:0] tx_sr;
  logic [7:0] serial_shift_register;
  logic [8:0] lim;
  logic       spi_tick;
  logic       mid_tick;
  logic       end_tick;
  logic       spi_start;
  logic       spi_done;
  logic       samp_mid;
  logic [7:0] rx_next;

  assign lim       = half_limit(rate_sel, baud_reload_value);
  assign spi_start = !i2c_mode && buf_wr && !spi_busy;
  assign spi_tick  = spi_busy && ((rate_sel == SSMI_RATE_TMR2) ? tmr2_tick
                                  : (div_cnt == lim - 9'h001));
  assign mid_tick  = spi_tick && !phase[0];
  assign end_tick  = spi_tick && phase[0];
  assign spi_done  = end_tick && (phase == SSMI_LAST_PHASE);
  assign samp_mid  = !sample_phase_bit && clock_edge_select;
  assign rx_next   = {serial_shift_register[6:0], serial_data_input};

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= 9'h000;
    end else if (ce) begin
      if (!spi_busy || spi_tick) begin
        div_cnt <= 9'h000;
      end else begin
        div_cnt <= div_cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      spi_busy <= 1'b0;
      phase    <= 4'h0;
    end else if (ce) begin
      if (spi_start) begin
        spi_busy <= 1'b1;
        phase    <= 4'h0;
      end else if (spi_tick) begin
        phase <= phase + 4'h1;
        if (spi_done) begin
          spi_busy <= 1'b0;
        end
      end
    end
  end

  // transmit side: msb first, launch point set by the edge bit
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sr              <= 8'h00;
      serial_data_output <= 1'b0;
    end else if (ce) begin
      if (spi_start) begin
        tx_sr <= buf_wdata;
        if (clock_edge_select) begin
          serial_data_output <= buf_wdata[7];
        end
      end else if (end_tick) begin
        tx_sr <= {tx_sr[6:0], 1'b0};
        if (clock_edge_select && !spi_done) begin
          serial_data_output <= tx_sr[6];
        end
      end else if (mid_tick && !clock_edge_select) begin
        serial_data_output <= tx_sr[7];
      end
    end
  end

  // receive side keeps shifting at the programmed rate
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_shift_register <= 8'h00;
    end else if (ce) begin
      if ((samp_mid && mid_tick) || (!samp_mid && end_tick)) begin
        serial_shift_register <= rx_next;
      end
    end
  end

  // idle level from the polarity bit; active level in the second half of each bit
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_out <= 1'b0;
    end else if (ce) begin
      sck_out <= clock_release_polarity_bit ^ (spi_busy && !end_tick
                 && (phase[0] || mid_tick));
    end
  end

  // ---------------- i2c slave ----------------
  ssmi_i2c_state_t state;
  logic       scl_d;
  logic       sda_d;
  logic [7:0] i2c_sr;
  logic [3:0] fall_cnt;
  logic       is_addr;
  logic       hold_scl;
  logic       ack_nack;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       byte_end;
  logic       ninth_end;
  logic       addr_ok;
  logic       hold_now;
  logic       ack_stretch;
  logic       i2c_byte_in;

  assign scl_rise    = i2c_mode && scl_in && !scl_d;
  assign scl_fall    = i2c_mode && !scl_in && scl_d;
  assign start_det   = i2c_mode && scl_in && scl_d && sda_d && !sda_in;
  assign stop_det    = i2c_mode && scl_in && scl_d && !sda_d && sda_in;
  assign byte_end    = scl_fall && (state == SSMI_I2C_RECV) && (fall_cnt == SSMI_BITS_BYTE);
  assign ninth_end   = scl_fall && (state == SSMI_I2C_ACK);
  assign addr_ok     = (i2c_sr[7:1] == own_address) && !i2c_sr[0];
  assign i2c_byte_in = byte_end && !start_det && !stop_det && (!is_addr || addr_ok);
  assign hold_now    = i2c_byte_in && (is_addr ? address_hold_enable : data_hold_enable);
  assign ack_stretch = ninth_end && !ack_nack && clock_stretch_enable;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce) begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= SSMI_I2C_IDLE;
      i2c_sr   <= 8'h00;
      fall_cnt <= 4'h0;
      is_addr  <= 1'b0;
    end else if (ce) begin
      if (!i2c_mode || stop_det) begin
        state <= SSMI_I2C_IDLE;
      end else if (start_det) begin
        state    <= SSMI_I2C_RECV;
        fall_cnt <= 4'h0;
        is_addr  <= 1'b1;
      end else begin
        unique case (state)
          SSMI_I2C_IDLE: begin
          end
          SSMI_I2C_RECV: begin
            // bits are counted on rises so the scl fall after a start is not one
            if (scl_rise) begin
              i2c_sr   <= {i2c_sr[6:0], sda_in};
              fall_cnt <= fall_cnt + 4'h1;
            end
            if (byte_end) begin
              state <= i2c_byte_in ? SSMI_I2C_ACK : SSMI_I2C_IDLE;
            end
          end
          SSMI_I2C_ACK: begin
            if (ninth_end) begin
              state    <= ack_nack ? SSMI_I2C_IDLE : SSMI_I2C_RECV;
              fall_cnt <= 4'h0;
              is_addr  <= 1'b0;
            end
          end
          default: state <= SSMI_I2C_IDLE;
        endcase
      end
    end
  end

  // acknowledge value: automatic ack unless software decides while held
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_nack <= 1'b0;
    end else if (ce) begin
      if (i2c_byte_in) begin
        ack_nack <= hold_now ? acknowledge_data_bit : 1'b0;
      end else if (hold_scl && state == SSMI_I2C_ACK) begin
        ack_nack <= acknowledge_data_bit;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_scl <= 1'b0;
    end else if (ce) begin
      if (hold_now || ack_stretch) begin
        hold_scl <= 1'b1;
      end else if (clock_release_polarity_bit || state == SSMI_I2C_IDLE) begin
        hold_scl <= 1'b0;
      end
    end
  end

  // open drain: output low, enable while pulling the line low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = hold_scl;
  assign sda_oe  = (state == SSMI_I2C_ACK) && !ack_nack;

  // ---------------- shared registers and flags ----------------
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_release_polarity_bit <= SSMI_CKP_RESET;
    end else if (ce) begin
      if (i2c_mode && (hold_now || ack_stretch)) begin
        clock_release_polarity_bit <= 1'b0;
      end else if (ckp_wr) begin
        clock_release_polarity_bit <= ckp_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_data_buffer <= SSMI_BUF_RESET;
    end else if (ce) begin
      if (spi_done) begin
        serial_data_buffer <= samp_mid ? serial_shift_register : rx_next;
      end else if (i2c_byte_in) begin
        serial_data_buffer <= i2c_sr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buffer_full_flag <= 1'b0;
    end else if (ce) begin
      if (spi_done || i2c_byte_in) begin
        buffer_full_flag <= 1'b1;
      end else if (buf_rd) begin
        buffer_full_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_interrupt_flag <= 1'b0;
    end else if (ce) begin
      if (spi_done || hold_now || (ninth_end && !ack_nack)
          || (start_det && start_int_enable) || (stop_det && stop_int_enable)) begin
        port_interrupt_flag <= 1'b1;
      end else if (pif_clr) begin
        port_interrupt_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
    end else if (ce) begin
      if (start_det) begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end else if (stop_det) begin
        stop_seen  <= 1'b1;
        start_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acknowledge_time_status <= 1'b0;
    end else if (ce) begin
      if (hold_now) begin
        acknowledge_time_status <= 1'b1;
      end else if (ninth_end || state == SSMI_I2C_IDLE) begin
        acknowledge_time_status <= 1'b0;
      end
    end
  end

endmodule : ssmi_port

/* File: ssmi_spi_slave.sv */
// spi slave partner model for the serial port block
`timescale 1ns/10ps
module ssmi_spi_slave (
  // clock seen with its active polarity
  input  wire logic       sck,
  input  wire logic       pol,
  // byte to return
  input  wire logic       load,
  input  wire logic [7:0] tx_in,
  // data lines
  input  wire logic       mosi,
  output logic            miso,
  output logic      [7:0] rx
);
  logic [7:0] sh  = 8'h00;
  logic       got = 1'b0;
  wire        k   = sck ^ pol;
  assign miso = sh[7];
  // load, sample on the leading edge of k, shift on its trailing edge
  // no shift before the first sample; fill keeps the line changing
  always @(posedge load or posedge k or negedge k) begin
    if (load) begin
      sh  <= tx_in;
      got <= 1'b0;
    end else if (k) begin
      rx  <= {rx[6:0], mosi};
      got <= 1'b1;
    end else if (got) begin
      sh <= {sh[6:0], ~sh[7]};
    end
  end
endmodule : ssmi_spi_slave

/* File: tb_ssmi_port.sv */
// testbench for the serial port block
`timescale 1ns/10ps
module tb_ssmi_port;
  import ssmi_pkg::*;
  logic clk = 0, rst = 1, ce = 1, i2c_mode = 0, buf_wr = 0, buf_rd = 0, ckp_wr = 0;
  logic ckp_wdata = 0, pif_clr = 0, clock_edge_select = 1, sample_phase_bit = 0;
  logic tmr2_tick = 0, address_hold_enable = 1, data_hold_enable = 1, load = 0;
  logic clock_stretch_enable = 1, acknowledge_data_bit = 0, start_int_enable = 1;
  logic stop_int_enable = 0, scl_m = 1, sda_m = 1;
  logic [7:0] buf_wdata = 8'h00, baud_reload_value = 8'h01, tx = 8'h00, rx;
  logic [2:0] rate_sel = 3'h0, n2 = 3'h0;
  logic [6:0] own_address = 7'h2c;
  logic [7:0] serial_data_buffer;
  logic clock_release_polarity_bit, port_interrupt_flag, buffer_full_flag, start_seen;
  logic stop_seen, acknowledge_time_status, spi_busy, sck_out, serial_data_output;
  logic scl_out, scl_oe, sda_out, sda_oe;
  wire  serial_data_input;
  wire  scl_in = scl_m & !scl_oe;
  wire  sda_in = sda_m & !sda_oe;
  int   fails = 0, checks_done = 0;

  ssmi_port DUT (.*);
  ssmi_spi_slave u_far (.sck(sck_out), .pol(clock_release_polarity_bit ^ !clock_edge_select),
    .load(load), .tx_in(tx), .mosi(serial_data_output), .miso(serial_data_input), .rx(rx));

  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    n2 <= n2 + 3'h1;
    tmr2_tick <= &n2;
  end

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task chk(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task sw_clear;
    pif_clr <= 1'b1;
    buf_rd <= 1'b1;
    @(posedge clk);
    pif_clr <= 1'b0;
    buf_rd <= 1'b0;
    cyc(2);
  endtask : sw_clear
  task final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task spi_byte(input logic [2:0] r, input logic e, p, s, input logic [7:0] d, m);
    int t, h;
    logic [2:0] f;
    h = (r == 3'h0) ? 2 : (r == 3'h2) ? 32 : (r == 3'h4) ? 4 : 8;
    rate_sel <= r;
    clock_edge_select <= e;
    sample_phase_bit <= s;
    ckp_wr <= 1'b1;
    ckp_wdata <= p;
    tx <= m;
    @(posedge clk);
    ckp_wr <= 1'b0;
    cyc(3);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    buf_wdata <= d;
    buf_wr <= 1'b1;
    @(posedge clk);
    buf_wr <= 1'b0;
    t = 0;
    @(posedge clk);
    while (spi_busy === 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
      // freeze the clock enable for eleven clocks, less than one bit of the byte
      if (t == 40 && r == 3'h1) begin
        ce <= 1'b0;
        cyc(2);
        f = {sck_out, serial_data_output, spi_busy};
        cyc(9);
        chk({sck_out, serial_data_output, spi_busy} === f, "ce freeze");
        ce <= 1'b1;
      end
    end
    cyc(2);
    chk(t > 15 * h - 3 && t < 17 * h, "spi byte length");
    chk(serial_data_buffer === m, "spi rx byte");
    chk(rx === d, "spi tx byte");
    chk(port_interrupt_flag === 1'b1 && buffer_full_flag === 1'b1, "spi flags");
    sw_clear;
    chk(port_interrupt_flag === 1'b0 && buffer_full_flag === 1'b0, "spi clear");
  endtask : spi_byte

  task ibit(input logic b);
    sda_m <= b;
    cyc(8);
    scl_m <= 1'b1;
    cyc(8);
    scl_m <= 1'b0;
    cyc(8);
  endtask : ibit
  task held(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) ibit(b[i]);
    chk(port_interrupt_flag === 1'b1 && buffer_full_flag === 1'b1, "hold flags");
    chk(clock_release_polarity_bit === 1'b0 && scl_oe === 1'b1, "hold scl");
    chk(acknowledge_time_status === 1'b1, "ack time");
    chk(serial_data_buffer === b, "i2c byte");
    sw_clear;
    chk(buffer_full_flag === 1'b0 && scl_oe === 1'b1, "read while held");
  endtask : held
  task ack(input logic a);
    acknowledge_data_bit <= a;
    ckp_wr <= 1'b1;
    ckp_wdata <= 1'b1;
    @(posedge clk);
    ckp_wr <= 1'b0;
    cyc(3);
    chk(scl_oe === 1'b0 && sda_oe === !a, "ack drive");
    ibit(1'b1);
    chk(port_interrupt_flag === !a && acknowledge_time_status === 1'b0, "ninth");
    chk(scl_oe === !a && sda_oe === 1'b0, "after ack");
    sw_clear;
    ckp_wr <= 1'b1;
    @(posedge clk);
    ckp_wr <= 1'b0;
    cyc(3);
  endtask : ack
  task i2c_rx;
    i2c_mode <= 1'b1;
    cyc(4);
    sda_m <= 1'b0;
    cyc(8);
    chk(start_seen === 1'b1 && port_interrupt_flag === 1'b1, "start");
    chk(scl_out === 1'b0 && sda_out === 1'b0, "open drain low");
    sw_clear;
    scl_m <= 1'b0;
    cyc(8);
    held({own_address, 1'b0});
    ack(1'b0);
    held(8'ha5);
    ack(1'b1);
    sda_m <= 1'b0;
    cyc(8);
    scl_m <= 1'b1;
    cyc(8);
    sda_m <= 1'b1;
    cyc(8);
    chk(stop_seen === 1'b1 && start_seen === 1'b0, "stop");
    chk(port_interrupt_flag === 1'b0, "stop quiet");
    // second frame: start interrupt off, stop interrupt on
    start_int_enable <= 1'b0;
    stop_int_enable <= 1'b1;
    sda_m <= 1'b0;
    cyc(8);
    chk(start_seen === 1'b1 && port_interrupt_flag === 1'b0, "start quiet");
    sda_m <= 1'b1;
    cyc(8);
    chk(stop_seen === 1'b1 && port_interrupt_flag === 1'b1, "stop flag");
  endtask : i2c_rx

  initial begin
    #100000;
    fails++;
    final_report;
  end
  initial begin
    cyc(12);
    rst <= 1'b0;
    @(posedge clk);
    spi_byte(3'h0, 1'b1, 1'b0, 1'b0, 8'h96, 8'h3c);
    spi_byte(3'h1, 1'b0, 1'b0, 1'b0, 8'h81, 8'h7e);
    spi_byte(3'h2, 1'b1, 1'b1, 1'b0, 8'h5a, 8'hc3);
    spi_byte(3'h3, 1'b1, 1'b0, 1'b1, 8'h0f, 8'he1);
    spi_byte(3'h4, 1'b1, 1'b1, 1'b1, 8'hf0, 8'h24);
    i2c_rx;
    final_report;
  end
endmodule : tb_ssmi_port
